// [inc/dbl_pkg.sv]
// Purpose: Constants and carrier types for the bay lock and power pin block.
// Assumes: pclk at 200 MHz; APB register access; two device bays.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
// How it works
// - Mode pin low: each interlock output follows its bay's lock control bit.
// - Level mode: active lock floats the open-drain pin, inactive drives low.
// - Mode pin high: lock bit falling one-to-zero drives pin low one interval.
// - Unlock interval picked by timing register: 120 ms, 500 ms, 1 s, 2 s.
// - Power output is active high; asserted enables enumeration power.
// - Power output follows the bay's power control bit.
// - Low on a removal request input means removal requested for that bay.
// - Removal request is debounced; its assertion raises a host interrupt.
// - Low on security lock status means lock present; high means absent.
// - Serial clock runs at most 100 kHz; faster edges are flagged.
// - Interrupt is active low and holds until software writes one.
// - After reset lock bit is one only if mode low and default pin high.
// - Reset pin is active high and acts after two clock samples high.
package dbl_pkg;

    localparam int NBAY = 2;
    localparam int CLK_KHZ = 200000;

    // Unlock pulse times in milliseconds and their cycle counts.
    localparam int PULSE0_MS = 120;
    localparam int PULSE1_MS = 500;
    localparam int PULSE2_MS = 1000;
    localparam int PULSE3_MS = 2000;
    localparam int PULSE0_CYC = PULSE0_MS * CLK_KHZ;
    localparam int PULSE1_CYC = PULSE1_MS * CLK_KHZ;
    localparam int PULSE2_CYC = PULSE2_MS * CLK_KHZ;
    localparam int PULSE3_CYC = PULSE3_MS * CLK_KHZ;
    localparam int PCNT_W = 29;

    // Removal request debounce time.
    localparam int DEB_MS = 100;
    localparam int DEB_CYC = DEB_MS * CLK_KHZ;
    localparam int DCNT_W = 25;

    // Shortest legal serial clock period, in cycles of pclk.
    localparam int SCL_MAX_KHZ = 100;
    localparam int SCL_CNT_W = 12;
    localparam logic [SCL_CNT_W-1:0] SCL_MIN_CYC =
        SCL_CNT_W'(CLK_KHZ / SCL_MAX_KHZ);

    // Cycles after reset before pin straps are trusted.
    // The strap synchroniser needs four edges, so loading earlier would
    // latch the reset value of the strap instead of the pin.
    localparam logic [2:0] BOOT_CYC = 3'h6;

    // Register map.
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TIMING = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PINS = 8'h10;

    // Field positions.
    localparam int CTRL_LOCK_LSB = 0;
    localparam int CTRL_PWR_LSB = 2;
    localparam int TIM_W = 2;
    localparam logic [TIM_W-1:0] TIM_RST = 2'h0;
    localparam int ST_W = 3;
    localparam int ST_REM_LSB = 0;
    localparam int ST_SCL_BIT = 2;
    localparam int PIN_REM_LSB = 0;
    localparam int PIN_SL_LSB = 2;
    localparam int PIN_PULSE_LSB = 4;
    localparam int PIN_LOCK_LSB = 6;
    localparam int PIN_PWR_LSB = 8;
    localparam int PIN_MODE_BIT = 10;

    // Positions of the asynchronous inputs in the synchroniser vector.
    localparam int IN_REM = 0;
    localparam int IN_SL = 2;
    localparam int IN_LCK = 4;
    localparam int IN_PWR = 6;
    localparam int IN_MODE = 8;
    localparam int IN_DEF = 9;
    localparam int IN_RST = 10;
    localparam int IN_SCL = 11;
    localparam int IN_W = 12;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } dbl_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dbl_apb_rsp_t;

endpackage

// [hw/dbl_in.sv]
// Purpose: Three-stage input synchroniser with an optional stable-time filter.
// Assumes: pin_async is asynchronous to pclk.
// Notes: With DEB_CYC of zero the level follows the agreed samples at once.
`timescale 1ns/1ps
module dbl_in #(
    parameter int DEB_CYC = 0,
    parameter int CNT_W = 25,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_async,
    output logic level
);
    import dbl_pkg::*;

    localparam logic [CNT_W-1:0] LIM =
        (DEB_CYC > 0) ? CNT_W'(DEB_CYC - 1) : '0;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic [CNT_W-1:0] cnt;
    } dbl_in_st_t;

    dbl_in_st_t r, n;

    if (DEB_CYC < 0 || DEB_CYC > (2 ** CNT_W)) begin : g_chk
        $error("dbl_in: DEB_CYC does not fit the counter");
    end

    // Only s2 reads s1; a change counts once s2 and s3 agree.
    always_comb begin
        n = r;
        n.s1 = pin_async;
        n.s2 = r.s1;
        n.s3 = r.s2;
        if (r.s2 == r.s3 && r.s3 != r.lvl) begin
            if (r.cnt >= LIM) begin
                n.lvl = r.s3;
                n.cnt = '0;
            end else begin
                n.cnt = CNT_W'(r.cnt + 1'b1);
            end
        end else begin
            n.cnt = '0;
        end
    end

    // Samples reset to the pin's idle level so no false edge follows reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.s1 <= RST_VAL;
            r.s2 <= RST_VAL;
            r.s3 <= RST_VAL;
            r.lvl <= RST_VAL;
        end else begin
            r <= n;
        end
    end

    assign level = r.lvl;

endmodule

// [hw/dbl_top.sv]
// Purpose: Bay interlock, power enable, removal request and lock status pins.
// Assumes: APB slave on pclk; every pin input is asynchronous to pclk.
// Notes: Open-drain pins drive low only; out is always zero, oe drives it.
`timescale 1ns/1ps
module dbl_top #(
    parameter int P0_CYC = dbl_pkg::PULSE0_CYC,
    parameter int P1_CYC = dbl_pkg::PULSE1_CYC,
    parameter int P2_CYC = dbl_pkg::PULSE2_CYC,
    parameter int P3_CYC = dbl_pkg::PULSE3_CYC,
    parameter int DEB_CYC = dbl_pkg::DEB_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire dbl_pkg::dbl_apb_req_t apb_req,
    output dbl_pkg::dbl_apb_rsp_t apb_rsp,
    input wire logic [dbl_pkg::NBAY-1:0] removal_request_n,
    input wire logic [dbl_pkg::NBAY-1:0] security_lock_status_n,
    input wire logic lock_mode_sel,
    input wire logic interlock_default_pin,
    input wire logic bay_reset_pin,
    input wire logic smb_clk_in,
    input wire logic [dbl_pkg::NBAY-1:0] interlock_in,
    output logic [dbl_pkg::NBAY-1:0] interlock_out,
    output logic [dbl_pkg::NBAY-1:0] interlock_oe,
    input wire logic [dbl_pkg::NBAY-1:0] bay_power_in,
    output logic [dbl_pkg::NBAY-1:0] bay_power_out,
    output logic [dbl_pkg::NBAY-1:0] bay_power_oe,
    output logic irq_n
);
    import dbl_pkg::*;

    typedef struct packed {
        logic [2:0] boot_cnt;
        logic boot_done;
        logic [NBAY-1:0] lock_ctrl;
        logic [NBAY-1:0] pwr_ctrl;
        logic [NBAY-1:0] rem_prev;
        logic [TIM_W-1:0] tim_sel;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [NBAY-1:0][PCNT_W-1:0] pulse_cnt;
        logic scl_prev;
        logic scl_seen;
        logic [SCL_CNT_W-1:0] scl_cnt;
        logic [NBAY-1:0] drv_low;
        logic [NBAY-1:0] lock_oe;
        logic [NBAY-1:0] pwr_oe;
        logic irq_n;
        dbl_apb_rsp_t rsp;
    } dbl_top_st_t;

    dbl_top_st_t r, n;
    logic [IN_W-1:0] pins_async;
    logic [IN_W-1:0] pins_q;
    logic [NBAY-1:0] rem_q, sl_q;
    logic mode_q, def_q, rst_q, scl_q;
    logic access, take, wr;
    logic [ST_W-1:0] ev, clr;

    // Refuse counts that overflow the pulse counter.
    if (P0_CYC < 1 || P1_CYC < 1 || P2_CYC < 1 || P3_CYC < 1 ||
        P3_CYC >= (2 ** PCNT_W) || P2_CYC >= (2 ** PCNT_W) ||
        P1_CYC >= (2 ** PCNT_W) || P0_CYC >= (2 ** PCNT_W)) begin : g_chk
        $error("dbl_top: pulse count out of range");
    end

    // Selected unlock pulse length in cycles.
    function automatic logic [PCNT_W-1:0] pulse_len(
        input logic [TIM_W-1:0] sel
    );
        case (sel)
            2'h0: pulse_len = PCNT_W'(P0_CYC);
            2'h1: pulse_len = PCNT_W'(P1_CYC);
            2'h2: pulse_len = PCNT_W'(P2_CYC);
            default: pulse_len = PCNT_W'(P3_CYC);
        endcase
    endfunction

    assign pins_async = {smb_clk_in, bay_reset_pin, interlock_default_pin,
                         lock_mode_sel, bay_power_in, interlock_in,
                         security_lock_status_n, removal_request_n};

    // One synchroniser per pin; only removal requests get the long filter.
    for (genvar g = 0; g < IN_W; g++) begin : g_in
        dbl_in #(
            .DEB_CYC((g >= IN_REM && g < IN_REM + NBAY) ? DEB_CYC : 0),
            .CNT_W(DCNT_W),
            .RST_VAL((g < IN_LCK) ? 1'b1 : 1'b0)
        ) u_in (
            .pclk(pclk),
            .presetn(presetn),
            .pin_async(pins_async[g]),
            .level(pins_q[g])
        );
    end

    assign rem_q = pins_q[IN_REM +: NBAY];
    assign sl_q = pins_q[IN_SL +: NBAY];
    assign mode_q = pins_q[IN_MODE];
    assign def_q = pins_q[IN_DEF];
    assign rst_q = pins_q[IN_RST];
    assign scl_q = pins_q[IN_SCL];

    // A request completes on the edge where pready is already high.
    assign access = apb_req.psel & apb_req.penable;
    assign take = access & r.rsp.pready;
    assign wr = take & apb_req.pwrite & apb_req.pstrb[0];

    // Whole next-state computation.
    always_comb begin
        n = r;
        ev = '0;
        clr = '0;
        n.rsp.pready = access & ~r.rsp.pready;
        n.rsp.pslverr = 1'b0;
        n.rsp.prdata = '0;
        // Read data are loaded as pready rises so they stand when sampled.
        if (access && !r.rsp.pready) begin
            case (apb_req.paddr)
                OFS_CTRL: begin
                    n.rsp.prdata[CTRL_LOCK_LSB +: NBAY] = r.lock_ctrl;
                    n.rsp.prdata[CTRL_PWR_LSB +: NBAY] = r.pwr_ctrl;
                end
                OFS_TIMING: n.rsp.prdata[TIM_W-1:0] = r.tim_sel;
                OFS_STATUS: n.rsp.prdata[ST_W-1:0] = r.status;
                OFS_MASK: n.rsp.prdata[ST_W-1:0] = r.mask;
                OFS_PINS: begin
                    n.rsp.prdata[PIN_REM_LSB +: NBAY] = ~rem_q;
                    n.rsp.prdata[PIN_SL_LSB +: NBAY] = ~sl_q;
                    for (int b = 0; b < NBAY; b++) begin
                        n.rsp.prdata[PIN_PULSE_LSB + b] =
                            (r.pulse_cnt[b] != '0);
                    end
                    n.rsp.prdata[PIN_LOCK_LSB +: NBAY] = pins_q[IN_LCK +: NBAY];
                    n.rsp.prdata[PIN_PWR_LSB +: NBAY] = pins_q[IN_PWR +: NBAY];
                    n.rsp.prdata[PIN_MODE_BIT] = mode_q;
                end
                default: n.rsp.pslverr = 1'b1;
            endcase
        end
        // Register writes.
        if (wr) begin
            case (apb_req.paddr)
                OFS_CTRL: begin
                    n.lock_ctrl = apb_req.pwdata[CTRL_LOCK_LSB +: NBAY];
                    n.pwr_ctrl = apb_req.pwdata[CTRL_PWR_LSB +: NBAY];
                end
                OFS_TIMING: n.tim_sel = apb_req.pwdata[TIM_W-1:0];
                OFS_STATUS: clr = apb_req.pwdata[ST_W-1:0];
                OFS_MASK: n.mask = apb_req.pwdata[ST_W-1:0];
                default: ;
            endcase
        end
        // Debounced removal request going low is the interrupt event.
        n.rem_prev = rem_q;
        ev[ST_REM_LSB +: NBAY] = r.rem_prev & ~rem_q;
        // Serial clock edges closer than the legal period are flagged.
        n.scl_prev = scl_q;
        if (scl_q && !r.scl_prev) begin
            ev[ST_SCL_BIT] = r.scl_seen
                && (r.scl_cnt < SCL_MIN_CYC);
            n.scl_cnt = '0;
            n.scl_seen = 1'b1;
        end else if (r.scl_cnt < SCL_MIN_CYC) begin
            n.scl_cnt = SCL_CNT_W'(r.scl_cnt + 1'b1);
        end
        // A new event beats a clear in the same cycle.
        n.status = (r.status & ~clr) | ev;
        // Reset pin and start-up: defaults reload, strap sampled after settling.
        if (rst_q) begin
            n.boot_cnt = '0;
            n.boot_done = 1'b0;
            n.lock_ctrl = '0;
            n.pwr_ctrl = '0;
            n.tim_sel = TIM_RST;
            n.status = '0;
            n.mask = '0;
        end else if (!r.boot_done) begin
            n.boot_cnt = 3'(r.boot_cnt + 1'b1);
            n.pwr_ctrl = '0;
            if (r.boot_cnt == BOOT_CYC - 3'h1) begin
                n.boot_done = 1'b1;
                n.lock_ctrl = {NBAY{~mode_q & def_q}};
            end
        end
        // Interlock: level follow or timed unlock pulse per bay.
        for (int b = 0; b < NBAY; b++) begin
            if (!mode_q || rst_q) begin
                n.pulse_cnt[b] = '0;
            end else if (r.boot_done && r.lock_ctrl[b] && !n.lock_ctrl[b]) begin
                n.pulse_cnt[b] = pulse_len(r.tim_sel);
            end else if (r.pulse_cnt[b] != '0) begin
                n.pulse_cnt[b] = PCNT_W'(r.pulse_cnt[b] - 1'b1);
            end
            n.lock_oe[b] = mode_q ? (n.pulse_cnt[b] != '0)
                                  : ~n.lock_ctrl[b];
        end
        // Power pin floats high when enabled and is pulled low otherwise.
        n.pwr_oe = ~n.pwr_ctrl;
        n.drv_low = '0;
        n.irq_n = ~|(n.status & n.mask);
    end

    // Reset leaves both pins driven low: unlocked and unpowered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.lock_oe <= '1;
            r.pwr_oe <= '1;
            r.irq_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign apb_rsp = r.rsp;
    assign interlock_out = r.drv_low;
    assign interlock_oe = r.lock_oe;
    assign bay_power_out = r.drv_low;
    assign bay_power_oe = r.pwr_oe;
    assign irq_n = r.irq_n;

    // Checks on the block's own outputs and internal registers.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The pins settle one cycle after a mode change, so that cycle is skipped.
    level_follow_a: assert property (
        r.boot_done && !mode_q && !$past(mode_q)
        |-> interlock_oe == ~r.lock_ctrl)
        else $error("interlock does not follow lock bit");
    level_float_a: assert property (
        !mode_q && !rst_q && r.lock_ctrl[0] |=> !mode_q |-> !interlock_oe[0]
        || !r.lock_ctrl[0])
        else $error("active lock is not released");
    pulse_start_a: assert property (
        $fell(r.lock_ctrl[0]) && mode_q && $past(mode_q) && $past(r.boot_done)
        && !$past(rst_q) |-> interlock_oe[0])
        else $error("unlock pulse did not start");
    pulse_len_a: assert property (
        $rose(r.pulse_cnt[0] != '0) |-> r.pulse_cnt[0] ==
        pulse_len($past(r.tim_sel)))
        else $error("unlock pulse length wrong");
    power_write_a: assert property (
        wr && apb_req.paddr == OFS_CTRL && !rst_q && r.boot_done
        |=> bay_power_oe[0] ==
        ~$past(apb_req.pwdata[CTRL_PWR_LSB]))
        else $error("power pin ignores control write");
    rem_event_a: assert property (
        $fell(rem_q[0]) && !rst_q ##1 !rst_q |-> r.status[ST_REM_LSB])
        else $error("removal request not flagged");
    irq_level_a: assert property (
        irq_n == !(|(r.status & r.mask)))
        else $error("interrupt output wrong");
    set_wins_a: assert property (
        ev[0] && clr[0] && !rst_q |=> r.status[0])
        else $error("event lost to clear");
    clear_w1c_a: assert property (
        clr[1] && !ev[1] && !rst_q |=> !r.status[1])
        else $error("status bit not cleared");
    strap_load_a: assert property (
        !r.boot_done && !rst_q && r.boot_cnt == BOOT_CYC - 3'h1
        |=> r.lock_ctrl == {NBAY{$past(~mode_q & def_q)}})
        else $error("lock default wrong");
    pin_reset_a: assert property (
        rst_q |=> r.pwr_ctrl == '0 && !r.boot_done)
        else $error("reset pin ignored");
    apb_wait_a: assert property (
        access && !apb_rsp.pready |=> apb_rsp.pready)
        else $error("pready late");

    pulse_c: cover property ($rose(interlock_oe[0]) && mode_q);
    irq_c: cover property ($fell(irq_n));
    scl_c: cover property ($rose(r.status[ST_SCL_BIT]));

endmodule

// [bench/dbl_bay_model.sv]
// Purpose: Bay hardware at the pins: pull-ups and a framed serial clock.
// Assumes: Open-drain pins float high through external pull-ups.
// Notes: The serial clock stands low outside frames.
`timescale 1ns/1ps
module dbl_bay_model (
    input wire logic [1:0] lock_oe,
    input wire logic [1:0] pwr_oe,
    input wire logic frame,
    output logic [1:0] lock_pin,
    output logic [1:0] pwr_pin,
    output logic smb_clk
);
    // A released pin rises through its pull-up; an enabled one is low.
    assign lock_pin = ~lock_oe;
    assign pwr_pin = ~pwr_oe;
    // A 64 ns clock is far above the rated rate, so the monitor must trip.
    initial begin
        smb_clk = 1'b0;
        forever begin
            #32;
            smb_clk = frame ? ~smb_clk : 1'b0;
        end
    end
endmodule

// [bench/tb_dbl_top.sv]
// Purpose: Self-checking bench for the bay pin block over APB.
// Assumes: Shortened pulse and debounce counts; strap gives locked default.
// Notes: Every wait is bounded; a bound that runs out counts a mismatch.
`timescale 1ns/1ps
module tb_dbl_top;
    import dbl_pkg::*;
    localparam int DEB = 8;
    localparam int PL[4] = '{20, 30, 40, 50};
    logic pclk;
    logic presetn;
    dbl_apb_req_t req;
    dbl_apb_rsp_t rsp;
    logic [1:0] rem_n, sl_n, lock_pin, pwr_pin, lock_oe, pwr_oe;
    logic [1:0] lock_out, pwr_out;
    logic mode, def, brst, frame, smb_clk, irq_n;
    logic [31:0] rd;
    logic err;
    int fail_count, total_checks;

    dbl_top #(.P0_CYC(PL[0]), .P1_CYC(PL[1]), .P2_CYC(PL[2]),
        .P3_CYC(PL[3]), .DEB_CYC(DEB)) dbl_top_i (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .removal_request_n(rem_n), .security_lock_status_n(sl_n),
        .lock_mode_sel(mode), .interlock_default_pin(def),
        .bay_reset_pin(brst), .smb_clk_in(smb_clk),
        .interlock_in(lock_pin), .interlock_out(lock_out),
        .interlock_oe(lock_oe),
        .bay_power_in(pwr_pin), .bay_power_out(pwr_out),
        .bay_power_oe(pwr_oe),
        .irq_n(irq_n));

    dbl_bay_model dbl_bay_model_i (.lock_oe(lock_oe), .pwr_oe(pwr_oe),
        .frame(frame), .lock_pin(lock_pin), .pwr_pin(pwr_pin),
        .smb_clk(smb_clk));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        int n;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= wd;
        req.pstrb <= 4'hF;
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        if (n >= 20) begin
            fail_count++;
            give_verdict();
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // The trailing edge keeps the next setup off this release.
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
        @(posedge pclk);
    endtask

    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
        @(posedge pclk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic sc_reset_state();
        rdr(OFS_CTRL);
        chk("ctrl after reset", rd, 32'h3);
        chk("lock oe after reset", 32'(lock_oe), 32'h0);
        chk("power oe after reset", 32'(pwr_oe), 32'h3);
        rdr(OFS_TIMING);
        chk("timing after reset", rd, 32'h0);
        rdr(8'h20);
        chk("unmapped error", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
    endtask

    task automatic sc_level();
        wr(OFS_CTRL, 32'h9);
        #1;
        chk("lock pins level", 32'(lock_pin), 32'h1);
        chk("lock oe level", 32'(lock_oe), 32'h2);
        chk("power pins", 32'(pwr_pin), 32'h2);
        chk("power oe", 32'(pwr_oe), 32'h1);
        chk("drive levels", 32'({lock_out, pwr_out}), 32'h0);
    endtask

    // Each timing code: a one-to-zero write opens a low pulse.
    task automatic sc_pulse();
        int n;
        mode <= 1'b1;
        cyc(8);
        for (int t = 0; t < 4; t++) begin
            wr(OFS_TIMING, 32'(t));
            wr(OFS_CTRL, 32'h1);
            apb(1'b1, OFS_CTRL, 32'h0);
            n = 0;
            #1;
            while (lock_oe[0] === 1'b1 && n < 100) begin
                n++;
                @(posedge pclk);
                #1;
            end
            chk("pulse length", 32'(n), 32'(PL[t]));
            @(posedge pclk);
        end
        mode <= 1'b0;
        cyc(8);
    endtask

    // A short glitch is ignored; a held request sets status and irq.
    task automatic sc_removal();
        int n;
        wr(OFS_MASK, 32'h3);
        rem_n <= 2'b01;
        cyc(4);
        rem_n <= 2'b11;
        cyc(DEB + 8);
        chk("glitch irq", 32'(irq_n), 32'h1);
        rem_n <= 2'b01;
        n = 0;
        while (irq_n !== 1'b0 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        chk("debounce time", 32'(n >= DEB && n <= DEB + 6),
            32'h1);
        rdr(OFS_STATUS);
        chk("removal status", rd & 32'h3, 32'h2);
        rdr(OFS_PINS);
        chk("removal active", rd & 32'h3, 32'h2);
        cyc(4);
        chk("irq held", 32'(irq_n), 32'h0);
        wr(OFS_STATUS, 32'h2);
        #1;
        chk("irq cleared", 32'(irq_n), 32'h1);
        wr(OFS_MASK, 32'h0);
        rem_n <= 2'b10;
        cyc(DEB + 10);
        chk("masked irq", 32'(irq_n), 32'h1);
        rdr(OFS_STATUS);
        chk("masked status", rd & 32'h3, 32'h1);
        wr(OFS_STATUS, 32'h3);
        rem_n <= 2'b11;
    endtask

    task automatic sc_lock_and_clock();
        sl_n <= 2'b01;
        frame <= 1'b1;
        // Long enough for several serial clock rises whatever the phase.
        cyc(80);
        frame <= 1'b0;
        rdr(OFS_PINS);
        chk("lock present", (rd >> 2) & 32'h3, 32'h2);
        rdr(OFS_STATUS);
        chk("clock overspeed", (rd >> 2) & 32'h1, 32'h1);
        wr(OFS_STATUS, 32'h4);
    endtask

    // One sample high is a glitch; two or more reset and reload strap.
    task automatic sc_soft_reset();
        wr(OFS_CTRL, 32'h0);
        brst <= 1'b1;
        @(posedge pclk);
        brst <= 1'b0;
        cyc(8);
        rdr(OFS_CTRL);
        chk("ctrl after glitch", rd, 32'h0);
        brst <= 1'b1;
        cyc(4);
        brst <= 1'b0;
        cyc(14);
        rdr(OFS_CTRL);
        chk("ctrl after soft reset", rd, 32'h3);
    endtask

    initial begin
        presetn = 1'b0;
        req = '0;
        rem_n = 2'b11;
        sl_n = 2'b11;
        mode = 1'b0;
        def = 1'b1;
        brst = 1'b0;
        frame = 1'b0;
        fail_count = 0;
        total_checks = 0;
        cyc(3);
        presetn <= 1'b1;
        cyc(10);
        sc_reset_state();
        sc_level();
        sc_pulse();
        sc_removal();
        sc_lock_and_clock();
        sc_soft_reset();
        give_verdict();
    end
endmodule
